// ==== cpl_pkg.sv ====
// Shared constants for the palette lookup port: register selects, widths, timing.
// Assumes one clock, CORE_CLK at 200 MHz, standing in for the pixel clock.
package cpl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned IDX_W         = 8;
  localparam int unsigned CHAN_W        = 6;
  localparam int unsigned ENTRY_W       = 18;
  localparam int unsigned DEPTH         = 256;
  localparam int unsigned PIPE_DEPTH    = 3;
  localparam logic [1:0]  SEL_WR_INDEX  = 2'h0;
  localparam logic [1:0]  SEL_COLOR     = 2'h1;
  localparam logic [1:0]  SEL_MASK      = 2'h2;
  localparam logic [1:0]  SEL_RD_INDEX  = 2'h3;
  localparam logic [7:0]  MASK_RESET    = 8'hFF;
  localparam logic [5:0]  BLANK_LEVEL   = 6'h00;
  // Recovery gaps in pixel periods after a strobe ends.
  localparam int unsigned GAP_PLAIN     = 4;
  localparam int unsigned GAP_COLOR_WR  = 4;
  localparam int unsigned GAP_COLOR_RD  = 7;
  localparam int unsigned GAP_RD_INDEX  = 7;
  // Host strobe timing in ns, converted to cycles (rounded up).
  localparam int unsigned STROBE_NS     = 50;
  localparam int unsigned SETUP_NS      = 15;
  localparam int unsigned STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pixel period of the device pipeline in host clock cycles.
  localparam int unsigned PIX_CYC       = 1;
  localparam logic [1:0]  BYTE_RED      = 2'h0;
  localparam logic [1:0]  BYTE_GREEN    = 2'h1;
  localparam logic [1:0]  BYTE_BLUE     = 2'h2;
endpackage

// ==== cpl_if.sv ====
// Interface joining the palette device and its host controller.
// Assumes only the two ends drive the data bus; an undriven bus reads inverted.
interface cpl_if;
  logic       wr_strobe_n;
  logic       rd_strobe_n;
  logic [1:0] reg_sel;
  logic [7:0] host_data_out;
  logic       host_data_oe_n;
  logic [7:0] dev_data_out;
  logic       dev_data_oe_n;
  logic [7:0] host_data_bus;
  assign host_data_bus = !dev_data_oe_n  ? dev_data_out :
                         !host_data_oe_n ? host_data_out : ~host_data_out;
  modport device (
    input  wr_strobe_n,
    input  rd_strobe_n,
    input  reg_sel,
    input  host_data_bus,
    output dev_data_out,
    output dev_data_oe_n
  );
  modport host (
    output wr_strobe_n,
    output rd_strobe_n,
    output reg_sel,
    output host_data_out,
    output host_data_oe_n,
    input  host_data_bus
  );
endinterface

// ==== cpl_device.sv ====
// Palette lookup device: pixel pipeline plus host strobe port.
// Assumes the host keeps the recovery gaps; strobes are synchronised here.
module cpl_device
  import cpl_pkg::*;
(
  // Clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             SYS_RST,
  // Pixel stream
  input  wire logic [7:0]       PIXEL_INDEX_IN,
  input  wire logic             BLANK_N,
  input  wire logic             STANDBY_REQUEST_N,
  // Color outputs
  output logic      [5:0]       RED_OUT,
  output logic      [5:0]       GREEN_OUT,
  output logic      [5:0]       BLUE_OUT,
  // Host port
  cpl_if.device                 bus
);
  logic [ENTRY_W-1:0] palette [DEPTH];
  // Strobe synchronisers: three flops, edge when second and third agree.
  logic [2:0] wr_sync_q, wr_sync_d;
  logic [2:0] rd_sync_q, rd_sync_d;
  logic       wr_lvl_q, wr_lvl_d, rd_lvl_q, rd_lvl_d;
  logic [1:0] sel_q, sel_d;
  logic [7:0] index_q, index_d, mask_q, mask_d;
  logic [1:0] byte_q, byte_d;
  logic [ENTRY_W-1:0] hold_q, hold_d;
  logic       commit_q, commit_d, fetch_q, fetch_d;
  logic [7:0] rdata_q, rdata_d;
  logic       oe_n_q, oe_n_d;
  // Pixel pipeline.
  logic [7:0] addr_q, addr_d;
  logic       blank1_q, blank1_d, blank2_q, blank2_d;
  logic [ENTRY_W-1:0] color_q, color_d;
  logic [5:0] red_q, red_d, green_q, green_d, blue_q, blue_d;
  logic       wr_start, wr_end, rd_start, rd_end;
  // Standby pin synchroniser and write data captured beside the strobe samples.
  logic [2:0] stby_sync_q, stby_sync_d;
  logic       stby_lvl_q, stby_lvl_d;
  logic [7:0] dat0_q, dat0_d, dat1_q, dat1_d, wdat_q, wdat_d;
  logic [ENTRY_W-1:0] look_q, look_d;
  logic       blank3_q, blank3_d;

  function automatic logic [5:0] chan(input logic [ENTRY_W-1:0] e, input logic [1:0] b);
    case (b)
      BYTE_RED:   chan = e[17:12];
      BYTE_GREEN: chan = e[11:6];
      default:    chan = e[5:0];
    endcase
  endfunction

  always_comb begin
    wr_sync_d = {wr_sync_q[1:0], bus.wr_strobe_n};
    rd_sync_d = {rd_sync_q[1:0], bus.rd_strobe_n};
    dat0_d    = bus.host_data_bus;
    dat1_d    = dat0_q;
    // The host releases the bus with the strobe, so keep data sampled while it was low.
    wdat_d    = !wr_sync_q[1] ? dat1_q : wdat_q;
    wr_lvl_d  = (wr_sync_q[1] == wr_sync_q[2]) ? wr_sync_q[2] : wr_lvl_q;
    rd_lvl_d  = (rd_sync_q[1] == rd_sync_q[2]) ? rd_sync_q[2] : rd_lvl_q;
    wr_start  = wr_lvl_q && !wr_lvl_d;
    wr_end    = !wr_lvl_q && wr_lvl_d;
    rd_start  = rd_lvl_q && !rd_lvl_d;
    rd_end    = !rd_lvl_q && rd_lvl_d;
    sel_d     = (wr_start || rd_start) ? bus.reg_sel : sel_q;
    index_d   = index_q;
    mask_d    = mask_q;
    byte_d    = byte_q;
    hold_d    = hold_q;
    commit_d  = 1'b0;
    fetch_d   = 1'b0;
    rdata_d   = rdata_q;
    oe_n_d    = oe_n_q;
    if (rd_start) begin
      oe_n_d = 1'b0;
      case (bus.reg_sel)
        SEL_COLOR: rdata_d = {2'h0, chan(hold_q, byte_q)};
        SEL_MASK:  rdata_d = mask_q;
        default:   rdata_d = index_q;
      endcase
    end
    if (rd_end) begin
      oe_n_d = 1'b1;
      if (sel_q == SEL_COLOR) begin
        if (byte_q == BYTE_BLUE) begin
          byte_d  = BYTE_RED;
          index_d = index_q + 8'h01;
          fetch_d = 1'b1;
        end else begin
          byte_d = byte_q + 2'h1;
        end
      end
    end
    if (wr_end) begin
      case (sel_q)
        SEL_WR_INDEX: begin
          index_d = wdat_q;
          byte_d  = BYTE_RED;
        end
        SEL_RD_INDEX: begin
          index_d = wdat_q;
          byte_d  = BYTE_RED;
          fetch_d = 1'b1;
        end
        SEL_MASK: mask_d = wdat_q;
        default: begin
          case (byte_q)
            BYTE_RED:   hold_d[17:12] = wdat_q[5:0];
            BYTE_GREEN: hold_d[11:6]  = wdat_q[5:0];
            default:    hold_d[5:0]   = wdat_q[5:0];
          endcase
          if (byte_q == BYTE_BLUE) begin
            byte_d   = BYTE_RED;
            commit_d = 1'b1;
          end else begin
            byte_d = byte_q + 2'h1;
          end
        end
      endcase
    end
    // Fetch of the current index into the holding register, a cycle after update.
    if (fetch_q) begin
      hold_d = palette[index_q];
    end
    // The committed entry lands at the current index, which then moves on.
    if (commit_q) begin
      index_d = index_q + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wr_sync_q <= 3'h7;
      rd_sync_q <= 3'h7;
      wr_lvl_q  <= 1'b1;
      rd_lvl_q  <= 1'b1;
      sel_q     <= SEL_WR_INDEX;
      index_q   <= 8'h00;
      mask_q    <= MASK_RESET;
      byte_q    <= BYTE_RED;
      hold_q    <= 18'h00000;
      commit_q  <= 1'b0;
      fetch_q   <= 1'b0;
      rdata_q   <= 8'h00;
      oe_n_q    <= 1'b1;
      dat0_q    <= 8'h00;
      dat1_q    <= 8'h00;
      wdat_q    <= 8'h00;
    end else begin
      wr_sync_q <= wr_sync_d;
      rd_sync_q <= rd_sync_d;
      wr_lvl_q  <= wr_lvl_d;
      rd_lvl_q  <= rd_lvl_d;
      sel_q     <= sel_d;
      index_q   <= index_d;
      mask_q    <= mask_d;
      byte_q    <= byte_d;
      hold_q    <= hold_d;
      commit_q  <= commit_d;
      fetch_q   <= fetch_d;
      rdata_q   <= rdata_d;
      oe_n_q    <= oe_n_d;
      dat0_q    <= dat0_d;
      dat1_q    <= dat1_d;
      wdat_q    <= wdat_d;
    end
  end

  // Palette store; the commit writes the entry then advances the index.
  always_ff @(posedge CORE_CLK) begin
    if (commit_q) begin
      palette[index_q] <= hold_q;
    end
  end

  always_comb begin
    // Mask, look up, hold, then blank: four stages from sample to output.
    stby_sync_d = {stby_sync_q[1:0], STANDBY_REQUEST_N};
    stby_lvl_d  = (stby_sync_q[1] == stby_sync_q[2]) ? stby_sync_q[2] : stby_lvl_q;
    addr_d   = PIXEL_INDEX_IN & mask_q;
    blank1_d = !BLANK_N;
    blank2_d = blank1_q;
    blank3_d = blank2_q;
    look_d   = palette[addr_q];
    color_d  = look_q;
    if (!stby_lvl_q) begin
      color_d = color_q;
    end
    red_d   = blank3_q ? BLANK_LEVEL : color_q[17:12];
    green_d = blank3_q ? BLANK_LEVEL : color_q[11:6];
    blue_d  = blank3_q ? BLANK_LEVEL : color_q[5:0];
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      addr_q   <= 8'h00;
      blank1_q <= 1'b1;
      blank2_q <= 1'b1;
      blank3_q <= 1'b1;
      look_q   <= 18'h00000;
      color_q  <= 18'h00000;
      stby_sync_q <= 3'h7;
      stby_lvl_q  <= 1'b1;
      red_q    <= BLANK_LEVEL;
      green_q  <= BLANK_LEVEL;
      blue_q   <= BLANK_LEVEL;
    end else begin
      addr_q   <= addr_d;
      blank1_q <= blank1_d;
      blank2_q <= blank2_d;
      blank3_q <= blank3_d;
      look_q   <= look_d;
      color_q  <= color_d;
      stby_sync_q <= stby_sync_d;
      stby_lvl_q  <= stby_lvl_d;
      red_q    <= red_d;
      green_q  <= green_d;
      blue_q   <= blue_d;
    end
  end

  assign RED_OUT           = red_q;
  assign GREEN_OUT         = green_q;
  assign BLUE_OUT          = blue_q;
  assign bus.dev_data_out  = rdata_q;
  assign bus.dev_data_oe_n = oe_n_q;
endmodule

// ==== cpl_host.sv ====
// Host controller end: turns one-cycle requests into paced strobes.
// Assumes the device counts one pixel period per CORE_CLK cycle.
module cpl_host
  import cpl_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // Request side
  input  wire logic       REQ_VALID,
  input  wire logic       REQ_WRITE,
  input  wire logic [1:0] REQ_SEL,
  input  wire logic [7:0] REQ_WDATA,
  output logic            REQ_READY,
  output logic            RSP_VALID,
  output logic [7:0]      RSP_RDATA,
  // Device side
  cpl_if.host             bus
);
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_PULSE = 2'b10,
    H_GAP   = 2'b11
  } cpl_hstate_t;
  cpl_hstate_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic       wr_q, wr_d, rsp_q, rsp_d, wrn_q, wrn_d, rdn_q, rdn_d, oen_q, oen_d;
  logic [1:0] sel_q, sel_d, byte_q, byte_d;
  logic [7:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] gap;
  logic       rdy_q, rdy_d;

  // Gap after the strobe, plus synchroniser margin of three cycles.
  always_comb begin
    gap = 4'(GAP_PLAIN);
    if (sel_q == SEL_COLOR && byte_q == BYTE_BLUE) begin
      gap = wr_q ? 4'(GAP_COLOR_WR) : 4'(GAP_COLOR_RD);
    end else if (sel_q == SEL_RD_INDEX && wr_q) begin
      gap = 4'(GAP_RD_INDEX);
    end
  end

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    wr_d   = wr_q;
    sel_d  = sel_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    byte_d = byte_q;
    rsp_d  = 1'b0;
    wrn_d  = wrn_q;
    rdn_d  = rdn_q;
    oen_d  = oen_q;
    case (st_q)
      H_IDLE: begin
        if (REQ_VALID) begin
          wr_d  = REQ_WRITE;
          sel_d = REQ_SEL;
          wd_d  = REQ_WDATA;
          oen_d = !REQ_WRITE;
          cnt_d = 4'(SETUP_CYC);
          st_d  = H_SETUP;
        end
      end
      H_SETUP: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          wrn_d = !wr_q;
          rdn_d = wr_q;
          cnt_d = 4'(STROBE_CYC) + 4'h3;
          st_d  = H_PULSE;
        end
      end
      H_PULSE: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          if (!wr_q) begin
            rd_d  = bus.host_data_bus;
            rsp_d = 1'b1;
          end
          wrn_d = 1'b1;
          rdn_d = 1'b1;
          oen_d = 1'b1;
          cnt_d = gap + 4'h3;
          st_d  = H_GAP;
          if (sel_q == SEL_COLOR) begin
            byte_d = (byte_q == BYTE_BLUE) ? BYTE_RED : byte_q + 2'h1;
          end else if (wr_q && sel_q != SEL_MASK) begin
            byte_d = BYTE_RED;
          end
        end
      end
      H_GAP: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
    rdy_d = (st_d == H_IDLE);
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_q   <= H_IDLE;
      cnt_q  <= 4'h0;
      wr_q   <= 1'b0;
      sel_q  <= 2'h0;
      wd_q   <= 8'h00;
      rd_q   <= 8'h00;
      byte_q <= BYTE_RED;
      rsp_q  <= 1'b0;
      wrn_q  <= 1'b1;
      rdn_q  <= 1'b1;
      oen_q  <= 1'b1;
      rdy_q  <= 1'b1;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      wr_q   <= wr_d;
      sel_q  <= sel_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      byte_q <= byte_d;
      rsp_q  <= rsp_d;
      wrn_q  <= wrn_d;
      rdn_q  <= rdn_d;
      oen_q  <= oen_d;
      rdy_q  <= rdy_d;
    end
  end

  assign REQ_READY          = rdy_q;
  assign RSP_VALID          = rsp_q;
  assign RSP_RDATA          = rd_q;
  assign bus.wr_strobe_n    = wrn_q;
  assign bus.rd_strobe_n    = rdn_q;
  assign bus.reg_sel        = sel_q;
  assign bus.host_data_out  = wd_q;
  assign bus.host_data_oe_n = oen_q;
endmodule

// ==== cpl_props.sv ====
// Checker for the strobe port between host end and palette device.
// Assumes the testbench instantiates it beside the joining interface.
module cpl_props
  import cpl_pkg::*;
(
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  // Interface signals
  input wire logic       wr_strobe_n,
  input wire logic       rd_strobe_n,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe_n,
  input wire logic [7:0] dev_data_out,
  input wire logic       dev_data_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] sel_q;
  logic [1:0] rbyte_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Select of the last strobe, kept through the gap; byte phase of color reads.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sel_q <= 2'h0;
      rbyte_q <= 2'h0;
    end else begin
      if (!wr_strobe_n || !rd_strobe_n)
        sel_q <= reg_sel;
      if ($rose(rd_strobe_n) && sel_q == SEL_COLOR)
        rbyte_q <= (rbyte_q == 2'h2) ? 2'h0 : rbyte_q + 2'h1;
      else if ($rose(wr_strobe_n) && sel_q == SEL_RD_INDEX)
        rbyte_q <= 2'h0;
    end
  end
  wr_gap_a: assert property ($rose(wr_strobe_n) |-> (wr_strobe_n && rd_strobe_n) [*4])
    else $error("write recovery gap too short");
  rd_gap_a: assert property ($rose(rd_strobe_n) |-> (wr_strobe_n && rd_strobe_n) [*4])
    else $error("read recovery gap too short");
  colwr_gap_a: assert property ($rose(wr_strobe_n) && sel_q == SEL_COLOR
    |-> (wr_strobe_n && rd_strobe_n) [*4]) else $error("color write gap too short");
  colrd_gap_a: assert property ($rose(rd_strobe_n) && sel_q == SEL_COLOR && rbyte_q == 2'h2
    |-> (wr_strobe_n && rd_strobe_n) [*7]) else $error("color read gap too short");
  rdidx_gap_a: assert property ($rose(wr_strobe_n) && sel_q == SEL_RD_INDEX
    |-> (wr_strobe_n && rd_strobe_n) [*7]) else $error("read index gap too short");
  top_zero_a: assert property (!dev_data_oe_n && sel_q == SEL_COLOR
    |-> dev_data_out[7:6] == 2'h0) else $error("color read top bits not zero");
  bus_single_a: assert property (!dev_data_oe_n |-> host_data_oe_n)
    else $error("both ends drive the data bus");
  wr_hold_a: assert property (!wr_strobe_n && $past(wr_strobe_n) == 1'b0
    |-> $stable(reg_sel) && $stable(host_data_out) && !host_data_oe_n)
    else $error("write select or data moved during strobe");
endmodule

// ==== cpl_tb.sv ====
// Testbench joining host end and palette device through the interface.
// Assumes one clock; requests go through the host end's request port.
module testbench
  import cpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst, blank_n, stby_n, vld, wr, rdy, rv;
  logic [1:0] sel;
  logic [7:0] pix, wd, rd, got;
  logic [5:0] red, grn, blu;
  int         err_count, cmp_count, cyc;
  logic [7:0] wv [9] = '{8'h01, 8'h02, 8'h03, 8'hFF, 8'hD5, 8'h2A, 8'h0C, 8'h30, 8'h21};
  cpl_if bus_if ();
  cpl_device cpl_device_i (.CORE_CLK(clk), .SYS_RST(rst), .PIXEL_INDEX_IN(pix),
    .BLANK_N(blank_n), .STANDBY_REQUEST_N(stby_n), .RED_OUT(red), .GREEN_OUT(grn),
    .BLUE_OUT(blu), .bus(bus_if));
  cpl_host cpl_host_i (.CORE_CLK(clk), .SYS_RST(rst), .REQ_VALID(vld), .REQ_WRITE(wr),
    .REQ_SEL(sel), .REQ_WDATA(wd), .REQ_READY(rdy), .RSP_VALID(rv), .RSP_RDATA(rd),
    .bus(bus_if));
  cpl_props cpl_props_i (.CORE_CLK(clk), .SYS_RST(rst), .wr_strobe_n(bus_if.wr_strobe_n),
    .rd_strobe_n(bus_if.rd_strobe_n), .reg_sel(bus_if.reg_sel),
    .host_data_out(bus_if.host_data_out), .host_data_oe_n(bus_if.host_data_oe_n),
    .dev_data_out(bus_if.dev_data_out), .dev_data_oe_n(bus_if.dev_data_oe_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // One host access; a read waits for the response pulse.
  task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    idle();
    vld = 1'b1;
    wr = w;
    sel = s;
    wd = d;
    @(posedge clk);
    #1;
    vld = 1'b0;
    r = 8'h00;
    n = 0;
    while (!w && rv !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    r = rd;
  endtask
  // Presents one pixel, then index zero, and checks the channels three edges on.
  task automatic pix_chk(input logic [7:0] idx, input logic bl, input logic [17:0] e);
    idle();
    pix = idx;
    blank_n = bl;
    @(posedge clk);
    #1;
    pix = 8'h00;
    blank_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({2'h0, red}, {2'h0, e[17:12]});
    chk({2'h0, grn}, {2'h0, e[11:6]});
    chk({2'h0, blu}, {2'h0, e[5:0]});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    {rst, blank_n, stby_n, vld, wr, sel, wd, pix} = {3'h7, 4'h0, 16'h0000};
    {err_count, cmp_count, cyc} = '0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    acc(1'b1, SEL_WR_INDEX, 8'h00, got);
    for (int k = 0; k < 6; k++) acc(1'b1, SEL_COLOR, wv[k], got);
    acc(1'b1, SEL_WR_INDEX, 8'h81, got);
    for (int k = 6; k < 9; k++) acc(1'b1, SEL_COLOR, wv[k], got);
    acc(1'b1, SEL_RD_INDEX, 8'h00, got);
    for (int k = 0; k < 6; k++) begin
      acc(1'b0, SEL_COLOR, 8'h00, got);
      chk(got, wv[k] & 8'h3F);
    end
    $display("test palette_rw done");
    pix_chk(8'h01, 1'b1, {wv[3][5:0], wv[4][5:0], wv[5][5:0]});
    pix_chk(8'h81, 1'b1, {wv[6][5:0], wv[7][5:0], wv[8][5:0]});
    pix_chk(8'h81, 1'b0, {3{BLANK_LEVEL}});
    acc(1'b1, SEL_MASK, 8'h7F, got);
    acc(1'b0, SEL_MASK, 8'h00, got);
    chk(got, 8'h7F);
    pix_chk(8'h81, 1'b1, {wv[3][5:0], wv[4][5:0], wv[5][5:0]});
    $display("test pixel_path done");
    stby_n = 1'b0;
    acc(1'b1, SEL_RD_INDEX, 8'h81, got);
    for (int k = 6; k < 9; k++) begin
      acc(1'b0, SEL_COLOR, 8'h00, got);
      chk(got, wv[k] & 8'h3F);
    end
    acc(1'b0, SEL_WR_INDEX, 8'h00, got);
    chk(got, 8'h82);
    pix_chk(8'h01, 1'b1, {wv[0][5:0], wv[1][5:0], wv[2][5:0]});
    $display("test standby_access done");
    test_done();
  end
endmodule
